/* File: pfr_read_port.v */
// Behaviour
// - setting the start bit launches one word read and hardware clears it at completion.
// - software writes of zero to the start bit have no effect.
// - the fetch takes the next two instruction cycles after start.
// - the fetched word stays in the data registers until the next read completes.
// - the two address bytes form one 13-bit word address.
// - the two data bytes present the 14-bit fetched word.
// - unused upper bits of high data and high address bytes read as zero.
// - control register bit 7 reads one and bits 6 to 1 read zero.
// - accesses through this port are whole-word reads only.
// - the address reaches up to 8K words.
// - internal reads proceed whatever the code-protect setting.
// - with code protection on, external programmer reads and writes are refused.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pfr_defs.vh"

module pfr_read_port #(
  parameter AW         = `PFR_ADDR_W,
  parameter DW         = `PFR_DATA_W,
  parameter INSTR_CYC  = `PFR_INSTR_CYC
) (
  input  wire          mclk_i,
  input  wire          rst_b_i,
  // ahb-lite slave
  input  wire          hsel_i,
  input  wire [31:0]   haddr_i,
  input  wire [1:0]    htrans_i,
  input  wire          hwrite_i,
  input  wire [2:0]    hsize_i,
  input  wire [31:0]   hwdata_i,
  input  wire          hready_i,
  output reg  [31:0]   hrdata_o,
  output reg           hreadyout_o,
  output reg           hresp_o,
  // code protect and external programmer port
  input  wire          code_protect_i,
  input  wire          xprog_wr_i,
  input  wire          xprog_rd_i,
  input  wire [AW-1:0] xprog_addr_i,
  input  wire [DW-1:0] xprog_wdata_i,
  output reg  [DW-1:0] xprog_rdata_o,
  output reg           xprog_refused_o,
  output reg           busy_o
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_FETCH = 2'h1;
  localparam ST_DONE  = 2'h2;
  localparam [15:0] FETCH_CYC = INSTR_CYC * `PFR_FETCH_INSTR;

  // ==================================================
  // bus address phase capture
  reg          wr_pend_ff;
  reg [11:0]   idx_ff;
  reg [7:0]    addr_lo_ff;
  reg [`PFR_ADDR_HI_W-1:0] addr_hi_ff;
  reg [DW-1:0] data_ff;
  reg [1:0]    state_ff;
  reg [15:0]   cnt_ff;
  reg          start_ff;
  reg          xp_rd_ff;
  reg          xp_refused_ff;

  wire xfer = hsel_i & hready_i & htrans_i[1];
  // word writes only; narrower write sizes are ignored
  // word only
  wire word = (hsize_i == `PFR_HSIZE_WORD) & (haddr_i[1:0] == 2'h0);

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_ff <= 1'b0;
      idx_ff     <= 12'h000;
    end else if (hready_i) begin
      wr_pend_ff <= xfer & hwrite_i & word;
      idx_ff     <= haddr_i[13:2];
    end
  end

  wire wr_ctrl = wr_pend_ff & (idx_ff == `PFR_IDX_CTRL);
  wire go = wr_ctrl & hwdata_i[`PFR_CTRL_START] & ~start_ff;

  // ==================================================
  // address registers
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= {`PFR_ADDR_HI_W{1'b0}};
    end else if (wr_pend_ff) begin
      if (idx_ff == `PFR_IDX_ADDR_LO) begin
        addr_lo_ff <= hwdata_i[7:0];
      end
      if (idx_ff == `PFR_IDX_ADDR_HI) begin
        addr_hi_ff <= hwdata_i[`PFR_ADDR_HI_W-1:0];
      end
    end
  end

  wire [AW-1:0] rd_addr = {addr_hi_ff, addr_lo_ff};

  // ==================================================
  // fetch sequencer
  wire [DW-1:0] mem_q;
  reg  [1:0]    nxt_state;
  reg  [15:0]   nxt_cnt;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (go) begin
          nxt_state = ST_FETCH;
          nxt_cnt   = FETCH_CYC - 16'h0001;
        end
      end
      ST_FETCH: begin
        if (cnt_ff == 16'h0001) begin
          nxt_state = ST_DONE;
        end
        nxt_cnt = cnt_ff - 16'h0001;
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 16'h0000;
      start_ff <= 1'b0;
      data_ff  <= {DW{1'b0}};
      busy_o   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      busy_o   <= (nxt_state != ST_IDLE);
      if (go) begin
        start_ff <= 1'b1;
      end else if (state_ff == ST_DONE) begin
        start_ff <= 1'b0;
      end
      if (state_ff == ST_DONE) begin
        data_ff <= mem_q;
      end
    end
  end

  // ==================================================
  // external programmer; internal path ignores protect
  // internal unaffected
  wire mem_rd = (state_ff == ST_FETCH) & (cnt_ff == 16'h0001)
              | (xprog_rd_i & ~code_protect_i);
  wire [AW-1:0] mem_ra = (state_ff == ST_FETCH) ? rd_addr : xprog_addr_i;

  wire xp_wr_ok = xprog_wr_i & ~code_protect_i;

  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xp_rd_ff        <= 1'b0;
      xp_refused_ff   <= 1'b0;
      xprog_rdata_o   <= {DW{1'b0}};
      xprog_refused_o <= 1'b0;
    end else begin
      xp_rd_ff        <= xprog_rd_i & ~code_protect_i & (state_ff != ST_FETCH);
      xp_refused_ff   <= (xprog_rd_i | xprog_wr_i) & code_protect_i;
      xprog_refused_o <= xp_refused_ff;
      if (xp_rd_ff) begin
        xprog_rdata_o <= mem_q;
      end
    end
  end

  pfr_flash_mem #(
    .AW (AW),
    .DW (DW)
  ) pfr_flash_mem_inst (
    .mclk_i    (mclk_i),
    .rd_en_i   (mem_rd),
    .rd_addr_i (mem_ra),
    .wr_en_i   (xp_wr_ok),
    .wr_addr_i (xprog_addr_i),
    .wr_data_i (xprog_wdata_i),
    .rd_data_o (mem_q)
  );

  // ==================================================
  // read mux; registered data phase, one wait state
  reg [31:0] rmux;
  always @* begin
    rmux = 32'h0000_0000;
    case (idx_ff)
      `PFR_IDX_ADDR_LO: rmux[7:0] = addr_lo_ff;
      `PFR_IDX_ADDR_HI: rmux[`PFR_ADDR_HI_W-1:0] = addr_hi_ff;
      `PFR_IDX_DATA_LO: rmux[7:0] = data_ff[7:0];
      `PFR_IDX_DATA_HI: rmux[`PFR_DATA_HI_W-1:0] = data_ff[DW-1:8];
      `PFR_IDX_CTRL: begin
        rmux[`PFR_CTRL_RSVD]  = 1'b1;
        rmux[`PFR_CTRL_START] = start_ff;
      end
      `PFR_IDX_STATUS: begin
        rmux[0] = code_protect_i;
        rmux[1] = busy_o;
      end
      default: rmux = 32'h0000_0000;
    endcase
  end

  reg rwait_ff;
  always @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rwait_ff    <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0000_0000;
      hresp_o     <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
      if (xfer & ~hwrite_i) begin
        rwait_ff    <= 1'b1;
        hreadyout_o <= 1'b0;
      end else if (rwait_ff) begin
        rwait_ff    <= 1'b0;
        hreadyout_o <= 1'b1;
        hrdata_o    <= rmux;
      end
    end
  end

endmodule // pfr_read_port
`default_nettype wire

/* File: pfr_defs.vh */
`ifndef PFR_DEFS_VH
`define PFR_DEFS_VH
// ==================================================
// register indices (byte address = index * 4)
`define PFR_IDX_DATA_LO   12'h10c
`define PFR_IDX_ADDR_LO   12'h10d
`define PFR_IDX_DATA_HI   12'h10e
`define PFR_IDX_ADDR_HI   12'h10f
`define PFR_IDX_CTRL      12'h18c
// ==================================================
// own status/config register index
`define PFR_IDX_STATUS    12'h190
// ==================================================
// field layout
`define PFR_ADDR_W        13
`define PFR_DATA_W        14
`define PFR_ADDR_HI_W     5
`define PFR_DATA_HI_W     6
`define PFR_CTRL_START    0
`define PFR_CTRL_RSVD     7
// ==================================================
// timing
`define PFR_INSTR_NS      200
`define PFR_CLK_NS        5
`define PFR_INSTR_CYC     (`PFR_INSTR_NS / `PFR_CLK_NS)
`define PFR_FETCH_INSTR   2
// ==================================================
// ahb encodings
`define PFR_HTRANS_NONSEQ 2'h2
`define PFR_HTRANS_SEQ    2'h3
`define PFR_HSIZE_WORD    3'h2
`endif

/* File: pfr_flash_mem.v */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// program flash array, registered read data
module pfr_flash_mem #(
  parameter AW = 13,
  parameter DW = 14
) (
  input  wire          mclk_i,
  input  wire          rd_en_i,
  input  wire [AW-1:0] rd_addr_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  output reg  [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule // pfr_flash_mem
`default_nettype wire

/* File: pfr_read_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// bus and fetch checks
module pfr_read_port_chk #(
  parameter INSTR_CYC = 4
) (
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        code_protect_i,
  input wire logic        xprog_rd_i,
  input wire logic        xprog_refused_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic acc = hsel_i && hready_i && htrans_i[1];
  property p_rd_wait;
    acc && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_wr_nowait;
    acc && hwrite_i |=> hreadyout_o;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  property p_one_wait;
    !hreadyout_o |=> hreadyout_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait state");
  // busy spans two instruction cycles (INSTR_CYC 4)
  property p_fetch_len;
    $rose(busy_o) |-> busy_o[*8] ##[1:3] !busy_o;
  endproperty
  a_fetch_len: assert property (p_fetch_len)
    else $error("fetch length wrong");
  property p_data_hold;
    hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("read data moved");
  property p_refuse;
    code_protect_i && xprog_rd_i |-> ##[1:2] xprog_refused_o;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("protected read not refused");
  property p_no_refuse;
    xprog_refused_o |-> $past(code_protect_i) || $past(code_protect_i, 2);
  endproperty
  a_no_refuse: assert property (p_no_refuse)
    else $error("refusal without protection");
  property p_resp_ok;
    hresp_o == 1'b0;
  endproperty
  a_resp_ok: assert property (p_resp_ok)
    else $error("response not okay");
endmodule // pfr_read_port_chk

bind pfr_read_port pfr_read_port_chk #(.INSTR_CYC(INSTR_CYC))
  pfr_read_port_chk_inst (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .code_protect_i(code_protect_i), .xprog_rd_i(xprog_rd_i),
  .xprog_refused_o(xprog_refused_o), .busy_o(busy_o)
);
`default_nettype wire

/* File: pfr_read_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfr_defs.vh"
module pfr_read_port_tb;
  logic        mclk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0;
  logic        hwrite_i = 1'b0, code_protect_i = 1'b0, seen;
  logic        xprog_wr_i = 1'b0, xprog_rd_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = `PFR_HSIZE_WORD;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, rd;
  logic [12:0] xprog_addr_i = 13'h0;
  logic [13:0] xprog_wdata_i = 14'h0;
  wire logic [31:0] hrdata_o;
  wire logic [13:0] xprog_rdata_o;
  wire logic        hreadyout_o, hresp_o, xprog_refused_o, busy_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 mclk_i = ~mclk_i;
  // short instruction cycle keeps fetches brief
  pfr_read_port #(.INSTR_CYC(4)) pfr_read_port_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .code_protect_i(code_protect_i), .xprog_wr_i(xprog_wr_i),
    .xprog_rd_i(xprog_rd_i), .xprog_addr_i(xprog_addr_i),
    .xprog_wdata_i(xprog_wdata_i), .xprog_rdata_o(xprog_rdata_o),
    .xprog_refused_o(xprog_refused_o), .busy_o(busy_o));
  task end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task ahb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= `PFR_HTRANS_NONSEQ;
    hwrite_i <= wr;
    haddr_i <= {18'h0, idx, 2'h0};
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
  endtask
  task xp(input logic wr, input logic [12:0] a, input logic [13:0] d);
    @(posedge mclk_i);
    xprog_wr_i <= wr;
    xprog_rd_i <= !wr;
    xprog_addr_i <= a;
    xprog_wdata_i <= d;
    @(posedge mclk_i);
    xprog_wr_i <= 1'b0;
    xprog_rd_i <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge mclk_i);
      seen |= (xprog_refused_o === 1'b1);
    end
  endtask
  task t_read(input logic [12:0] a, input logic [13:0] d);
    ahb(1'b1, `PFR_IDX_ADDR_HI, {27'h0, a[12:8]});
    ahb(1'b1, `PFR_IDX_ADDR_LO, {24'h0, a[7:0]});
    ahb(1'b1, `PFR_IDX_CTRL, 32'h1);
    ahb(1'b0, `PFR_IDX_CTRL, 32'h0);
    chk("ctrl busy", 32'h81, rd);
    for (int i = 0; i < 20 && rd[0] !== 1'b0; i++)
      ahb(1'b0, `PFR_IDX_CTRL, 32'h0);
    chk("ctrl done", 32'h80, rd);
    ahb(1'b0, `PFR_IDX_DATA_LO, 32'h0);
    chk("data lo", {24'h0, d[7:0]}, rd);
    ahb(1'b0, `PFR_IDX_DATA_HI, 32'h0);
    chk("data hi", {26'h0, d[13:8]}, rd);
    ahb(1'b0, `PFR_IDX_ADDR_HI, 32'h0);
    chk("addr hi", {27'h0, a[12:8]}, rd);
  endtask
  task t_hold(input logic [13:0] d);
    ahb(1'b1, `PFR_IDX_ADDR_LO, 32'h0);
    ahb(1'b1, `PFR_IDX_CTRL, 32'h0);
    ahb(1'b0, `PFR_IDX_CTRL, 32'h0);
    chk("ctrl zero wr", 32'h80, rd);
    ahb(1'b0, `PFR_IDX_DATA_LO, 32'h0);
    chk("data held", {24'h0, d[7:0]}, rd);
    ahb(1'b0, 12'h000, 32'h0);
    chk("unmapped", 32'h0, rd);
    hsize_i <= 3'h0;
    ahb(1'b1, `PFR_IDX_ADDR_HI, 32'h1f);
    hsize_i <= `PFR_HSIZE_WORD;
    ahb(1'b0, `PFR_IDX_ADDR_HI, 32'h0);
    chk("narrow wr", 32'h0, rd);
  endtask
  task t_protect;
    code_protect_i <= 1'b1;
    xp(1'b0, 13'h1fff, 14'h0);
    chk("refused", 32'h1, {31'h0, seen});
    xp(1'b1, 13'h1fff, 14'h0);
    chk("wr refused", 32'h1, {31'h0, seen});
    t_read(13'h1fff, 14'h2abc);
    code_protect_i <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    xp(1'b1, 13'h1fff, 14'h2abc);
    xp(1'b1, 13'h00a5, 14'h1557);
    xp(1'b0, 13'h00a5, 14'h0);
    chk("xprog rd", 32'h1557, {18'h0, xprog_rdata_o});
    chk("no refuse", 32'h0, {31'h0, seen});
    t_read(13'h1fff, 14'h2abc);
    t_read(13'h00a5, 14'h1557);
    t_hold(14'h1557);
    t_protect;
    end_sim;
  end
  // far beyond the few hundred cycles the run needs
  initial begin
    #20000;
    n_mismatch++;
    end_sim;
  end
endmodule // pfr_read_port_tb
`default_nettype wire
